// ---- mpio_pkg.sv ----
// Shared constants and carrier types for the multi-port pin block
package mpio_pkg;

	// Clock and timing
	localparam int CLK_MHZ = 25;
	localparam int CLK_PERIOD_NS = 40;
	localparam int TRI_REFRESH_NS = 1000;
	localparam int TRI_REFRESH_RAW = (TRI_REFRESH_NS * CLK_MHZ) / 1000;
	localparam int TRI_REFRESH_CYC = (TRI_REFRESH_RAW < 1) ? 1 : TRI_REFRESH_RAW;

	// Register byte offsets
	localparam logic [11:0] OFS_ANA_RD = 12'h000;
	localparam logic [11:0] OFS_FIXED = 12'h004;
	localparam logic [11:0] OFS_DIR = 12'h008;
	localparam logic [11:0] OFS_TRI = 12'h00C;
	localparam logic [11:0] OFS_LEVEL = 12'h010;
	localparam logic [11:0] OFS_LEVEL_ALT = 12'h014;
	localparam logic [11:0] OFS_PIN_OP = 12'h018;
	localparam logic [11:0] OFS_BIDIR_RD = 12'h01C;
	localparam logic [11:0] OFS_INONLY_RD = 12'h020;
	localparam logic [11:0] OFS_ALT = 12'h024;
	localparam logic [11:0] OFS_DUTY1 = 12'h028;
	localparam logic [11:0] OFS_DUTY2 = 12'h02C;
	localparam logic [11:0] OFS_HWTRI = 12'h030;
	localparam logic [11:0] OFS_SPECIAL = 12'h034;

	// Field positions
	localparam int PINOP_IDX_LSB = 0;
	localparam int PINOP_LVL_BIT = 8;
	localparam int ALT_PWM1_BIT = 0;
	localparam int ALT_PWM2_BIT = 1;
	localparam int ALT_TW_BIT = 2;
	localparam int PWM1_PIN = 1;
	localparam int PWM2_PIN = 2;
	localparam int TW_SCL_PIN = 3;
	localparam int TW_SDA_PIN = 4;
	localparam int IR_PIN = 0;
	localparam int KB_CLK_PIN = 6;
	localparam int KB_DATA_PIN = 7;

	// Reset values and response codes
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] HWTRI_RST = 8'hFF;
	localparam logic [7:0] LEVEL_RST = 8'h00;
	localparam logic [7:0] FIXED_RST = 8'h00;
	localparam logic [2:0] ALT_RST = 3'h0;
	localparam logic [4:0] SPECIAL_RST = 5'h03;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Carriers
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
	} mpio_bidir_t;

	typedef struct packed {
		logic ir_rx;
		logic kb_clk;
		logic kb_data;
		logic tw_scl;
		logic tw_sda;
	} mpio_special_t;

endpackage : mpio_pkg

// ---- mpio_pin_cell.sv ----
// One pin of the bidirectional port: direction, level and alternate function
`timescale 1ns/1ps
module mpio_pin_cell import mpio_pkg::*; (
	// Clock
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Control
	input wire logic tri_in,
	input wire logic level,
	input wire logic alt_sel,
	input wire logic alt_drive,
	input wire logic alt_o,
	// Pin
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe,
	output logic rd_val
);

	typedef struct packed {
		logic o;
		logic oe;
		logic rd;
	} mpio_cell_st_t;

	mpio_cell_st_t st_r;
	mpio_cell_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (alt_sel) begin
			st_nxt.oe = alt_drive;
			st_nxt.o = alt_drive & alt_o;
		end else begin
			st_nxt.oe = ~tri_in;
			st_nxt.o = level;
		end
		// Driven pins read back the latch, inputs the live level
		st_nxt.rd = st_nxt.oe ? st_nxt.o : pin_i;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign pin_o = st_r.o;
	assign pin_oe = st_r.oe;
	assign rd_val = st_r.rd;

endmodule : mpio_pin_cell

// ---- mpio_pwm.sv ----
// Free-running pulse-width generator for one alternate output
`timescale 1ns/1ps
module mpio_pwm import mpio_pkg::*; #(
	parameter int PWM_W = 8
) (
	// Clock
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Control
	input wire logic en,
	input wire logic [PWM_W-1:0] duty,
	// Output
	output logic pwm_o
);

	typedef struct packed {
		logic [PWM_W-1:0] cnt;
		logic o;
	} mpio_pwm_st_t;

	mpio_pwm_st_t st_r;
	mpio_pwm_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		// Counter held in reset while idle so each enable starts a clean period
		st_nxt.cnt = en ? st_r.cnt + 1'b1 : '0;
		st_nxt.o = en && (st_r.cnt < duty);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign pwm_o = st_r.o;

endmodule : mpio_pwm

// ---- mpio_top.sv ----
// Port arrangement block: analog, fixed output, bidirectional and input-only ports
//
// Function
// - Analog port resets analog, digitally readable
// - Analog port gives static levels only
// - Fixed output port always driven
// - Analog-only port always analog, no direction
// - Input-only port is standard digital input
// - Bidirectional port resets to all inputs
// - Single-pin set switches to output, drives level
// - Direction word: one bit, 1 output
// - Tristate view inverted: 1 input
// - Hardware tristate periodically refreshed from direction
// - Level word sets all outputs, two aliases
// - Pins 1,2 pwm; pins 3,4 two-wire
// - Input-only pins 0,6,7 infrared and keyboard
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module mpio_top import mpio_pkg::*; #(
	parameter bit LARGE_PKG = 1'b1,
	parameter int PWM_W = 8,
	parameter int REFRESH_CYC = TRI_REFRESH_CYC
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [11:0] awaddr,
	// Write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// Write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// Read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [11:0] araddr,
	// Read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Analog-capable port
	input wire logic [3:0] ana_i,
	output logic [3:0] ana_analog_en,
	// Fixed output port
	output logic [7:0] fixed_output_port_o,
	output logic [7:0] fixed_output_port_oe,
	// Bidirectional port
	input wire logic [7:0] bidir_i,
	output mpio_bidir_t bidir,
	// Input-only and analog-only ports
	input wire logic [7:0] input_only_port_i,
	output logic [2:0] analog_only_port_en,
	// Special function levels
	output mpio_special_t special
);

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	if (PWM_W < 2 || PWM_W > 8) begin : g_bad_pwm
		$error("PWM_W must lie between 2 and 8");
	end
	if (REFRESH_CYC < 1 || REFRESH_CYC > 65535) begin : g_bad_ref
		$error("REFRESH_CYC must lie between 1 and 65535");
	end

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic aw_h;
		logic [11:0] awaddr;
		logic w_h;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] fixed;
		logic [7:0] dir;
		logic [7:0] hwtri;
		logic [7:0] level;
		logic [2:0] alt;
		logic [PWM_W-1:0] duty1;
		logic [PWM_W-1:0] duty2;
		logic [15:0] ref_cnt;
		logic [3:0] ana_rd;
		logic [7:0] inonly_rd;
		mpio_special_t spec;
	} mpio_main_st_t;

	mpio_main_st_t st_r;
	mpio_main_st_t st_nxt;
	logic [7:0] rd_vec;
	logic [7:0] alt_sel_v;
	logic [7:0] alt_drive_v;
	logic [7:0] alt_o_v;
	logic pwm1;
	logic pwm2;
	logic wr_go;
	logic rd_go;

	////////////////////////////////////////////////////////////////////////////////
	// Pulse-width generators and pin cells

	mpio_pwm #(.PWM_W(PWM_W)) u_pwm1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.en(st_r.alt[ALT_PWM1_BIT]),
		.duty(st_r.duty1),
		.pwm_o(pwm1)
	);

	mpio_pwm #(.PWM_W(PWM_W)) u_pwm2 (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.en(st_r.alt[ALT_PWM2_BIT]),
		.duty(st_r.duty2),
		.pwm_o(pwm2)
	);

	for (genvar i = 0; i < 8; i++) begin : g_pin
		// Two-wire pins are only sampled here, never driven
		assign alt_sel_v[i] = (i == PWM1_PIN && st_r.alt[ALT_PWM1_BIT]) ||
			(i == PWM2_PIN && st_r.alt[ALT_PWM2_BIT]) ||
			((i == TW_SCL_PIN || i == TW_SDA_PIN) && st_r.alt[ALT_TW_BIT]);
		assign alt_drive_v[i] = (i == PWM1_PIN) || (i == PWM2_PIN);
		assign alt_o_v[i] = (i == PWM1_PIN) ? pwm1 : ((i == PWM2_PIN) ? pwm2 : 1'b0);
		mpio_pin_cell u_cell (
			.aclk(aclk),
			.aresetn(aresetn),
			.ce(ce),
			.tri_in(st_r.hwtri[i]),
			.level(st_r.level[i]),
			.alt_sel(alt_sel_v[i]),
			.alt_drive(alt_drive_v[i]),
			.alt_o(alt_o_v[i]),
			.pin_i(bidir_i[i]),
			.pin_o(bidir.o[i]),
			.pin_oe(bidir.oe[i]),
			.rd_val(rd_vec[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshakes

	assign awready = ce && !st_r.aw_h;
	assign wready = ce && !st_r.w_h;
	assign arready = ce && !st_r.rvalid;
	assign wr_go = st_r.aw_h && st_r.w_h && !st_r.bvalid;
	assign rd_go = arvalid && arready;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_nxt = st_r;
		// Pin sampling; the analog port feeds nothing but a static read
		st_nxt.ana_rd = ana_i;
		st_nxt.inonly_rd = LARGE_PKG ? input_only_port_i : 8'h00;
		st_nxt.spec.ir_rx = LARGE_PKG && input_only_port_i[IR_PIN];
		st_nxt.spec.kb_clk = LARGE_PKG && input_only_port_i[KB_CLK_PIN];
		st_nxt.spec.kb_data = LARGE_PKG && input_only_port_i[KB_DATA_PIN];
		st_nxt.spec.tw_scl = !st_r.alt[ALT_TW_BIT] || bidir_i[TW_SCL_PIN];
		st_nxt.spec.tw_sda = !st_r.alt[ALT_TW_BIT] || bidir_i[TW_SDA_PIN];
		// Periodic refresh; a raw tristate write survives only until here
		if (st_r.ref_cnt == 16'h0000) begin
			st_nxt.ref_cnt = 16'(REFRESH_CYC - 1);
			st_nxt.hwtri = ~st_r.dir;
		end else begin
			st_nxt.ref_cnt = st_r.ref_cnt - 16'h0001;
		end
		if (awvalid && awready) begin
			st_nxt.aw_h = 1'b1;
			st_nxt.awaddr = awaddr;
		end
		if (wvalid && wready) begin
			st_nxt.w_h = 1'b1;
			st_nxt.wdata = wdata;
			st_nxt.wstrb = wstrb;
		end
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (wr_go) begin
			st_nxt.aw_h = 1'b0;
			st_nxt.w_h = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			unique case (st_r.awaddr)
				OFS_ANA_RD, OFS_BIDIR_RD, OFS_INONLY_RD, OFS_SPECIAL: begin
				end
				OFS_FIXED: begin
					if (st_r.wstrb[0]) st_nxt.fixed = st_r.wdata[7:0];
				end
				OFS_DIR: begin
					if (st_r.wstrb[0]) begin
						st_nxt.dir = st_r.wdata[7:0];
						st_nxt.hwtri = ~st_r.wdata[7:0];
					end
				end
				OFS_TRI: begin
					if (st_r.wstrb[0]) begin
						st_nxt.dir = ~st_r.wdata[7:0];
						st_nxt.hwtri = st_r.wdata[7:0];
					end
				end
				OFS_LEVEL, OFS_LEVEL_ALT: begin
					if (st_r.wstrb[0]) st_nxt.level = st_r.wdata[7:0];
				end
				OFS_PIN_OP: begin
					if (st_r.wstrb[0] && st_r.wstrb[1]) begin
						st_nxt.dir[st_r.wdata[PINOP_IDX_LSB +: 3]] = 1'b1;
						st_nxt.hwtri[st_r.wdata[PINOP_IDX_LSB +: 3]] = 1'b0;
						st_nxt.level[st_r.wdata[PINOP_IDX_LSB +: 3]] =
							st_r.wdata[PINOP_LVL_BIT];
					end
				end
				OFS_ALT: begin
					if (st_r.wstrb[0]) st_nxt.alt = st_r.wdata[2:0];
				end
				OFS_DUTY1: begin
					if (st_r.wstrb[0]) st_nxt.duty1 = st_r.wdata[PWM_W-1:0];
				end
				OFS_DUTY2: begin
					if (st_r.wstrb[0]) st_nxt.duty2 = st_r.wdata[PWM_W-1:0];
				end
				OFS_HWTRI: begin
					if (st_r.wstrb[0]) st_nxt.hwtri = st_r.wdata[7:0];
				end
				default: begin
					st_nxt.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (rd_go) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			unique case (araddr)
				OFS_ANA_RD: st_nxt.rdata = 32'(st_r.ana_rd);
				OFS_FIXED: st_nxt.rdata = 32'(st_r.fixed);
				OFS_DIR: st_nxt.rdata = 32'(st_r.dir);
				// Invert before widening so the upper bits read zero
				OFS_TRI: st_nxt.rdata = {24'h00_0000, ~st_r.dir};
				OFS_LEVEL, OFS_LEVEL_ALT: st_nxt.rdata = 32'(st_r.level);
				OFS_PIN_OP: st_nxt.rdata = 32'h0000_0000;
				OFS_BIDIR_RD: st_nxt.rdata = 32'(rd_vec);
				OFS_INONLY_RD: st_nxt.rdata = 32'(st_r.inonly_rd);
				OFS_ALT: st_nxt.rdata = 32'(st_r.alt);
				OFS_DUTY1: st_nxt.rdata = 32'(st_r.duty1);
				OFS_DUTY2: st_nxt.rdata = 32'(st_r.duty2);
				OFS_HWTRI: st_nxt.rdata = 32'(st_r.hwtri);
				OFS_SPECIAL: st_nxt.rdata = 32'(st_r.spec);
				default: begin
					st_nxt.rdata = 32'h0000_0000;
					st_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.fixed <= FIXED_RST;
			st_r.dir <= DIR_RST;
			st_r.hwtri <= HWTRI_RST;
			st_r.level <= LEVEL_RST;
			st_r.alt <= ALT_RST;
			st_r.spec <= SPECIAL_RST;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign bvalid = st_r.bvalid;
	assign bresp = st_r.bresp;
	assign rvalid = st_r.rvalid;
	assign rdata = st_r.rdata;
	assign rresp = st_r.rresp;
	// No digital direction exists on these ports at all
	assign ana_analog_en = 4'hF;
	assign analog_only_port_en = LARGE_PKG ? 3'h7 : 3'h0;
	assign fixed_output_port_o = st_r.fixed;
	assign fixed_output_port_oe = 8'hFF;
	assign special = st_r.spec;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wr(logic [11:0] ofs);
		ce && wr_go && st_r.awaddr == ofs && st_r.wstrb[0];
	endsequence

	sequence s_pin_op;
		ce && wr_go && st_r.awaddr == OFS_PIN_OP && st_r.wstrb[1:0] == 2'h3;
	endsequence

	property p_ana_read;
		(ce && rd_go && araddr == OFS_ANA_RD) |=> rdata == 32'($past(ana_i, 2));
	endproperty
	a_ana_read: assert property (p_ana_read) else $error("analog digital read wrong");

	property p_fixed_drive;
		fixed_output_port_oe == 8'hFF && analog_only_port_en == (LARGE_PKG ? 3'h7 : 3'h0);
	endproperty
	a_fixed_drive: assert property (p_fixed_drive) else $error("fixed port enable lost");

	property p_reset_inputs;
		!$past(aresetn) |-> st_r.dir == 8'h00 && st_r.hwtri == 8'hFF;
	endproperty
	a_reset_inputs: assert property (p_reset_inputs) else $error("port not input at reset");

	property p_pin_op;
		logic [2:0] idx;
		logic lv;
		(s_pin_op, idx = st_r.wdata[2:0], lv = st_r.wdata[PINOP_LVL_BIT])
			|=> st_r.dir[idx] && st_r.level[idx] == lv;
	endproperty
	a_pin_op: assert property (p_pin_op) else $error("single pin op failed");

	property p_dir_write;
		s_wr(OFS_DIR) |=> st_r.dir == $past(st_r.wdata[7:0]) && st_r.hwtri == ~st_r.dir;
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direction write wrong");

	property p_tri_write;
		s_wr(OFS_TRI) |=> st_r.dir == ~$past(st_r.wdata[7:0]);
	endproperty
	a_tri_write: assert property (p_tri_write) else $error("tristate view wrong");

	property p_refresh;
		(ce && st_r.ref_cnt == 16'h0000 && !wr_go) |=> st_r.hwtri == ~st_r.dir;
	endproperty
	a_refresh: assert property (p_refresh) else $error("tristate not refreshed");

	property p_level_alias;
		s_wr(OFS_LEVEL_ALT) |=> st_r.level == $past(st_r.wdata[7:0]);
	endproperty
	a_level_alias: assert property (p_level_alias) else $error("level alias not stored");

	property p_pwm_pin;
		(ce && st_r.alt[ALT_PWM1_BIT]) [*2] |=> bidir.oe[PWM1_PIN] || !ce;
	endproperty
	a_pwm_pin: assert property (p_pwm_pin) else $error("pwm pin not driven");

	property p_ir;
		ce |=> special.ir_rx == (LARGE_PKG && $past(input_only_port_i[IR_PIN]));
	endproperty
	a_ir: assert property (p_ir) else $error("infrared input not passed");

	property p_out_level;
		(ce && !alt_sel_v[5] && !st_r.hwtri[5]) |=> !ce || bidir.o[5] == $past(st_r.level[5]);
	endproperty
	a_out_level: assert property (p_out_level) else $error("output pin level wrong");

endmodule : mpio_top

// ---- mpio_pins_model.sv ----
// Pin-side model: switches on the inputs, loads on the driven pins
`timescale 1ns/1ps
module mpio_pins_model import mpio_pkg::*; (
	// Switch settings
	input wire logic [3:0] ana_sw,
	input wire logic [7:0] bid_sw,
	input wire logic [7:0] in_sw,
	// Device side
	input wire mpio_bidir_t bidir,
	output logic [3:0] ana_i,
	output logic [7:0] bidir_i,
	output logic [7:0] input_only_port_i
);
	////////////////////////////////////////////////////////////////
	// Driven pins win over the switch, so a read sees the latch
	assign bidir_i = (bidir.oe & bidir.o) | (~bidir.oe & bid_sw);
	assign ana_i = ana_sw;
	assign input_only_port_i = in_sw;
endmodule : mpio_pins_model

// ---- tb_multi_port_io_config.sv ----
// Self-checking bench for the multi-port pin block
`timescale 1ns/1ps
module tb_multi_port_io_config import mpio_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic [3:0] ana_sw = 4'h0;
	logic [7:0] bid_sw = 8'h00;
	logic [7:0] in_sw = 8'h00;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rr;
	logic [31:0] rdata, rv;
	logic [3:0] ana_i, ana_en;
	logic [7:0] fix_o, fix_oe, bidir_i, in_i;
	logic [2:0] aonly_en;
	mpio_bidir_t bidir;
	mpio_special_t special;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	int h1, h2;
	logic [2:0] sm_aonly_en;
	mpio_special_t sm_special;

	////////////////////////////////////////////////////////////////
	always #20 aclk = ~aclk;

	mpio_top #(.REFRESH_CYC(4)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .ana_i(ana_i),
		.ana_analog_en(ana_en), .fixed_output_port_o(fix_o), .fixed_output_port_oe(fix_oe),
		.bidir_i(bidir_i), .bidir(bidir), .input_only_port_i(in_i),
		.analog_only_port_en(aonly_en), .special(special));

	mpio_pins_model pins (.ana_sw(ana_sw), .bid_sw(bid_sw), .in_sw(in_sw), .bidir(bidir),
		.ana_i(ana_i), .bidir_i(bidir_i), .input_only_port_i(in_i));

	// Smaller package variant: only its static pin-side outputs are watched
	mpio_top #(.LARGE_PKG(1'b0), .REFRESH_CYC(4)) dut_small (.aclk(aclk), .aresetn(aresetn),
		.ce(ce), .awvalid(1'b0), .awready(), .awaddr(12'h000), .wvalid(1'b0), .wready(),
		.wdata(32'h0000_0000), .wstrb(4'h0), .bvalid(), .bready(1'b0), .bresp(),
		.arvalid(1'b0), .arready(), .araddr(12'h000), .rvalid(), .rready(1'b0), .rdata(),
		.rresp(), .ana_i(ana_i), .ana_analog_en(), .fixed_output_port_o(),
		.fixed_output_port_oe(), .bidir_i(bidir_i), .bidir(), .input_only_port_i(in_i),
		.analog_only_port_en(sm_aonly_en), .special(sm_special));

	////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic c8(input string nm, input logic [7:0] e, input logic [7:0] g);
		chk(nm, {24'h00_0000, e}, {24'h00_0000, g});
	endtask : c8

	// Master holds each channel until its own ready, never assumes latency
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, bv;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		bready <= 1'b1;
		bv = 1'b0;
		while (!bv) begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			bv = bvalid;
			rr = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		c8("bresp", {6'h00, er}, {6'h00, rr});
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er,
		input string nm);
		logic ta, rvv;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		rvv = 1'b0;
		while (!rvv) begin
			@(negedge aclk);
			ta = arvalid & arready;
			rvv = rvalid;
			rv = rdata;
			rr = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk(nm, {24'h00_0000, e}, rv);
		c8("rresp", {6'h00, er}, {6'h00, rr});
	endtask : rd

	// Pin outputs lag the register by one edge; three cycles covers it
	task automatic settle;
		repeat (3) @(negedge aclk);
	endtask : settle

	task automatic tdone(input string nm);
		$display("test %s done", nm);
	endtask : tdone

	////////////////////////////////////////////////////////////////
	// Generous ceiling: the sequence needs well under 3000 cycles
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		c8("oe", 8'h00, bidir.oe);
		c8("fixed_oe", 8'hFF, fix_oe);
		c8("ana_en", 8'h0F, {4'h0, ana_en});
		c8("aonly_en", 8'h07, {5'h00, aonly_en});
		rd(OFS_DIR, 8'h00, RESP_OKAY, "dir");
		rd(OFS_TRI, 8'hFF, RESP_OKAY, "tri");
		rd(12'h100, 8'h00, RESP_SLVERR, "unmapped");
		wr(12'h100, 32'h0000_00FF, RESP_SLVERR);
		tdone("reset");
		ana_sw <= 4'hA;
		in_sw <= 8'hC1;
		settle();
		rd(OFS_ANA_RD, 8'h0A, RESP_OKAY, "ana_rd");
		rd(OFS_INONLY_RD, 8'hC1, RESP_OKAY, "inonly");
		@(negedge aclk);
		c8("special", 8'h07, {5'h00, special[4:2]});
		c8("small_aonly", 8'h00, {5'h00, sm_aonly_en});
		c8("small_special", 8'h00, {5'h00, sm_special[4:2]});
		@(posedge aclk);
		in_sw <= 8'h3E;
		ana_sw <= 4'h5;
		settle();
		c8("special", 8'h00, {5'h00, special[4:2]});
		rd(OFS_ANA_RD, 8'h05, RESP_OKAY, "ana_static");
		// Clock enable low must freeze the sampled pins
		@(posedge aclk);
		ce <= 1'b0;
		in_sw <= 8'hC1;
		settle();
		c8("ce_hold", 8'h00, {5'h00, special[4:2]});
		@(posedge aclk);
		ce <= 1'b1;
		settle();
		c8("ce_run", 8'h07, {5'h00, special[4:2]});
		tdone("inputs");
		wr(OFS_FIXED, 32'h0000_00A5, RESP_OKAY);
		settle();
		c8("fixed_o", 8'hA5, fix_o);
		wr(OFS_DIR, 32'h0000_00FF, RESP_OKAY);
		settle();
		c8("oe", 8'hFF, bidir.oe);
		rd(OFS_TRI, 8'h00, RESP_OKAY, "tri");
		wr(OFS_DIR, 32'h0000_0000, RESP_OKAY);
		settle();
		c8("oe", 8'h00, bidir.oe);
		wr(OFS_TRI, 32'h0000_000F, RESP_OKAY);
		settle();
		c8("oe", 8'hF0, bidir.oe);
		rd(OFS_DIR, 8'hF0, RESP_OKAY, "dir");
		tdone("direction");
		bid_sw <= 8'h96;
		wr(OFS_LEVEL, 32'h0000_003C, RESP_OKAY);
		settle();
		rd(OFS_LEVEL_ALT, 8'h3C, RESP_OKAY, "level_alt");
		@(negedge aclk);
		c8("drive", 8'h30, bidir.o & bidir.oe);
		rd(OFS_BIDIR_RD, 8'h36, RESP_OKAY, "bidir_rd");
		wr(OFS_LEVEL_ALT, 32'h0000_00FF, RESP_OKAY);
		settle();
		c8("drive", 8'hF0, bidir.o & bidir.oe);
		tdone("level");
		wr(OFS_DIR, 32'h0000_0000, RESP_OKAY);
		wr(OFS_PIN_OP, 32'h0000_0105, RESP_OKAY);
		wr(OFS_PIN_OP, 32'h0000_0006, RESP_OKAY);
		settle();
		c8("oe", 8'h60, bidir.oe);
		c8("drive", 8'h20, bidir.o & bidir.oe);
		tdone("pin_op");
		wr(OFS_DIR, 32'h0000_000F, RESP_OKAY);
		wr(OFS_HWTRI, 32'h0000_0000, RESP_OKAY);
		repeat (12) @(negedge aclk);
		rd(OFS_HWTRI, 8'hF0, RESP_OKAY, "hwtri");
		@(negedge aclk);
		c8("oe", 8'h0F, bidir.oe);
		tdone("refresh");
		wr(OFS_DUTY1, 32'h0000_0080, RESP_OKAY);
		wr(OFS_DUTY2, 32'h0000_0000, RESP_OKAY);
		wr(OFS_ALT, 32'h0000_0003, RESP_OKAY);
		settle();
		h1 = 0;
		h2 = 0;
		repeat (256) begin
			@(negedge aclk);
			h1 += int'(bidir.o[1] & bidir.oe[1]);
			h2 += int'(bidir.o[2] & bidir.oe[2]);
		end
		c8("pwm1_high", 8'h80, h1[7:0]);
		c8("pwm2_high", 8'h00, h2[7:0]);
		bid_sw <= 8'h00;
		wr(OFS_DIR, 32'h0000_00FF, RESP_OKAY);
		wr(OFS_ALT, 32'h0000_0004, RESP_OKAY);
		settle();
		c8("tw_oe", 8'h00, bidir.oe & 8'h18);
		c8("tw_lines", 8'h00, {6'h00, special[1:0]});
		tdone("alternate");
		report_and_stop();
	end
endmodule : tb_multi_port_io_config
